// ---- inc/agw_map.svh ----
// Register offsets, field positions, reset values and timing counts.
// Assumes an 8-bit register port with byte-wide index addresses.
`ifndef AGW_MAP_SVH
`define AGW_MAP_SVH
`define AGW_PIN24_CONFIG_ADDR 8'hec
`define AGW_PIN25_CONFIG_ADDR 8'hed
`define AGW_RESERVED_EE_ADDR 8'hee
`define AGW_COMBINED_IRQ_TWO_ADDR 8'hef
`define AGW_COMBINED_IRQ_ONE_ADDR 8'hf0
`define AGW_DECODE_STROBE_ENABLE_ADDR 8'hf1
`define AGW_WATCHDOG_TIMEOUT_VALUE_ADDR 8'hf2
`define AGW_EVENT_STATUS_ADDR 8'hf8
`define AGW_EVENT_MASK_ADDR 8'hf9
`define AGW_PIN_CFG_RESET 8'h01
`define AGW_ZERO_RESET 8'h00
`define AGW_PIN_CFG_MASK24 8'h1f
`define AGW_PIN_CFG_MASK25 8'h0f
`define AGW_IRQ_CFG_MASK 8'hf8
`define AGW_DEC_EN_MASK 8'h83
`define AGW_BIT_DIR 0
`define AGW_BIT_POL 1
`define AGW_BIT_INTEN 2
`define AGW_BIT_ALT 3
`define AGW_FUNC_LSB 3
`define AGW_BIT_FILTER 3
`define AGW_IRQ_MAP_LSB 4
`define AGW_BIT_DEC_EN 0
`define AGW_BIT_STROBE_EN 1
`define AGW_BIT_UNIT_SEC 7
`define AGW_IRQ_MAP_INVALID 4'h2
`define AGW_CLK_HZ 20000000
`define AGW_SECOND_CYCLES (`AGW_CLK_HZ)
`define AGW_SECONDS_PER_MINUTE 60
`define AGW_DEBOUNCE_CYCLES 16
`endif

// ---- inc/agw_pkg.sv ----
// Types shared by the auxiliary I/O slice and its pin stage.
// Assumes the map header supplies all numeric constants.
package agw_pkg;
  typedef enum logic [1:0] {
    AGW_FUNC_GPIO = 2'h0,
    AGW_FUNC_EEPROM_EN = 2'h1,
    AGW_FUNC_EDGE_IRQ3 = 2'h2,
    AGW_FUNC_RSVD = 2'h3
  } agw_func_e;
  typedef enum logic [2:0] {
    AGW_WD_IDLE = 3'h1,
    AGW_WD_COUNT = 3'h2,
    AGW_WD_EXPIRED = 3'h4
  } agw_wd_state_e;
endpackage

// ---- inc/agw_pin_if.sv ----
// Interface carrying one pin's configuration and conditioned level.
// Assumes a single clock domain shared by both ends.
`timescale 1ns/1ns
interface agw_pin_if;
  logic polarity_inv;
  logic filter_en;
  logic raw_level;
  logic cond_level;
  modport ctrl (output polarity_inv, output filter_en, output raw_level, input cond_level);
  modport cond (input polarity_inv, input filter_en, input raw_level, output cond_level);
endinterface

// ---- verilog/agw_pin_cond.sv ----
// Pin conditioning: polarity inversion and an optional debounce filter.
// Assumes the raw level is already synchronised to core_clk_in.
`timescale 1ns/1ns
`include "agw_map.svh"
module agw_pin_cond
  import agw_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic reset_in,
  agw_pin_if.cond pin
);
  logic [4:0] stable_cnt_r;
  logic filt_r;
  wire logic pol_level = pin.raw_level ^ pin.polarity_inv;
  wire logic differs = pol_level != filt_r;
  wire logic settled = stable_cnt_r == 5'(`AGW_DEBOUNCE_CYCLES - 1);

  // The filter only follows a level that has held for the whole window.
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in || !differs)
      stable_cnt_r <= 5'h00;
    else if (settled)
      stable_cnt_r <= 5'h00;
    else
      stable_cnt_r <= stable_cnt_r + 5'h01;
  end

  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
      filt_r <= 1'b0;
    else if (differs && settled)
      filt_r <= pol_level;
  end

  // Bypass trades glitch immunity for zero added latency.
  assign pin.cond_level = pin.filter_en ? filt_r : pol_level;
endmodule

// ---- verilog/agw_aux_io.sv ----
// Auxiliary I/O slice: two pin configs, combined IRQ routing, decoder
// enables and the watchdog timeout counter. Assumes a simple register
// port on core_clk_in and asynchronous pins that are synchronised here.
// Functional notes
// - Pin config bit 0 sets direction, one input, zero output.
// - Pin config bit 1 inverts the pin value when one.
// - Pin config bit 2 includes the pin in the combined interrupt.
// - First pin function 00 GPIO, 01 EEPROM enable, 10 edge IRQ3, 11 reserved.
// - Second pin bit 3 routes the gate for address line 20 to the pin.
// - Combined IRQ bit 3 enables the debounce filter, zero bypasses it; only combined IRQ one bit 3 acts here, for both pins.
// - Combined IRQ bits 7:4 select IRQ line; 0000 disables, 0010 invalid.
// - Reserved bits hold zero.
// - Decoder enable bit 0 switches the address decoder on.
// - Decoder enable bit 1 switches the write strobe on.
// - With activate clear, decoder and strobe enables have no effect.
// - Decoder enable bit 7 selects timeout unit, zero minutes, one seconds.
// - Timeout value zero disables the watchdog.
// - Nonzero timeout value is a binary count of units, 1 to 255.
// - Combined IRQ one, decoder enable and timeout value reset to zero.
// - On expiry the watchdog status bit sets; while clear, counting continues.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ns
`include "agw_map.svh"
module agw_aux_io
  import agw_pkg::*;
#(
  parameter int unsigned SECOND_CYCLES = `AGW_SECOND_CYCLES
)
(
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic device_active_in,
  input wire logic gate_a20_in,
  input wire logic eeprom_enable_in,
  input wire logic watchdog_clear_in,
  input wire logic [1:0] gpio_pin_in,
  output logic [1:0] gpio_pin_out,
  output logic [1:0] gpio_pin_oe_out,
  output logic edge_irq3_out,
  output logic [15:0] combined_irq_one_out,
  output logic [15:0] combined_irq_two_out,
  output logic general_address_decoder_en_out,
  output logic general_write_strobe_en_out,
  output logic watchdog_status_out,
  output logic irq_out
);
  logic [7:0] pin24_config_r;
  logic [7:0] pin25_config_r;
  logic [7:0] combined_irq_two_r;
  logic [7:0] combined_irq_one_r;
  logic [7:0] decode_strobe_enable_r;
  logic [7:0] watchdog_timeout_value_r;
  logic [1:0] gpio_out_r;
  logic [1:0] event_status_r;
  logic [1:0] event_mask_r;
  logic [7:0] rdata_r;
  logic [1:0] pin_meta_r;
  logic [1:0] pin_sync_r;
  logic [1:0] cond_prev_r;
  logic [31:0] sec_cnt_r;
  logic [5:0] min_cnt_r;
  logic [7:0] unit_cnt_r;
  logic wd_status_r;
  agw_wd_state_e wd_state_r;
  agw_wd_state_e wd_state_nxt;

  // Maps a four-bit routing field onto a one-hot IRQ line vector.
  function automatic logic [15:0] irq_route(input logic [7:0] cfg, input logic level);
    logic [3:0] line;
    line = cfg[7:`AGW_IRQ_MAP_LSB];
    irq_route = 16'h0000;
    if (level && line != 4'h0 && line != `AGW_IRQ_MAP_INVALID)
      irq_route[line] = 1'b1;
  endfunction

  // Register write decode.
  wire logic wr_pin24 = reg_wr_in && reg_addr_in == `AGW_PIN24_CONFIG_ADDR;
  wire logic wr_pin25 = reg_wr_in && reg_addr_in == `AGW_PIN25_CONFIG_ADDR;
  wire logic wr_irq2 = reg_wr_in && reg_addr_in == `AGW_COMBINED_IRQ_TWO_ADDR;
  wire logic wr_irq1 = reg_wr_in && reg_addr_in == `AGW_COMBINED_IRQ_ONE_ADDR;
  wire logic wr_dec = reg_wr_in && reg_addr_in == `AGW_DECODE_STROBE_ENABLE_ADDR;
  wire logic wr_wdv = reg_wr_in && reg_addr_in == `AGW_WATCHDOG_TIMEOUT_VALUE_ADDR;
  wire logic wr_stat = reg_wr_in && reg_addr_in == `AGW_EVENT_STATUS_ADDR;
  wire logic wr_mask = reg_wr_in && reg_addr_in == `AGW_EVENT_MASK_ADDR;

  // First pin config; the mask keeps bits 7:5 at zero.
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
      pin24_config_r <= `AGW_PIN_CFG_RESET;
    else if (wr_pin24)
      pin24_config_r <= reg_wdata_in & `AGW_PIN_CFG_MASK24;
  end

  // Second pin config; the mask keeps bits 7:4 at zero.
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
      pin25_config_r <= `AGW_PIN_CFG_RESET;
    else if (wr_pin25)
      pin25_config_r <= reg_wdata_in & `AGW_PIN_CFG_MASK25;
  end

  // Second routing register; only routing and filter bits are kept.
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
      combined_irq_two_r <= `AGW_ZERO_RESET;
    else if (wr_irq2)
      combined_irq_two_r <= reg_wdata_in & `AGW_IRQ_CFG_MASK;
  end

  // First routing register; it also owns the debounce select for both pins.
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
      combined_irq_one_r <= `AGW_ZERO_RESET;
    else if (wr_irq1)
      combined_irq_one_r <= reg_wdata_in & `AGW_IRQ_CFG_MASK;
  end

  // Decoder and strobe enables plus the watchdog unit select.
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
      decode_strobe_enable_r <= `AGW_ZERO_RESET;
    else if (wr_dec)
      decode_strobe_enable_r <= reg_wdata_in & `AGW_DEC_EN_MASK;
  end

  // Watchdog timeout value; all eight bits are significant.
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
      watchdog_timeout_value_r <= `AGW_ZERO_RESET;
    else if (wr_wdv)
      watchdog_timeout_value_r <= reg_wdata_in;
  end

  // Event mask; unmasked status bits drive the level interrupt.
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
      event_mask_r <= 2'h0;
    else if (wr_mask)
      event_mask_r <= reg_wdata_in[1:0];
  end

  // Pin output data has no register of its own; bits 1:0 are taken from
  // the data of every write to the event status index, whatever the pin direction.
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
      gpio_out_r <= 2'h0;
    else if (reg_wr_in && reg_addr_in == `AGW_RESERVED_EE_ADDR + 8'h0a)
      gpio_out_r <= reg_wdata_in[1:0];
  end

  // Two-stage synchroniser; only the second stage is read.
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      pin_meta_r <= 2'h0;
      pin_sync_r <= 2'h0;
    end
    else
    begin
      pin_meta_r <= gpio_pin_in;
      pin_sync_r <= pin_meta_r;
    end
  end

  // Per-pin conditioning; filter select follows the first routing register.
  agw_pin_if pin_a ();
  agw_pin_if pin_b ();
  assign pin_a.polarity_inv = pin24_config_r[`AGW_BIT_POL];
  assign pin_b.polarity_inv = pin25_config_r[`AGW_BIT_POL];
  assign pin_a.filter_en = combined_irq_one_r[`AGW_BIT_FILTER];
  assign pin_b.filter_en = combined_irq_one_r[`AGW_BIT_FILTER];
  assign pin_a.raw_level = pin_sync_r[0];
  assign pin_b.raw_level = pin_sync_r[1];
  agw_pin_cond u_cond_a (.core_clk_in(core_clk_in), .reset_in(reset_in), .pin(pin_a));
  agw_pin_cond u_cond_b (.core_clk_in(core_clk_in), .reset_in(reset_in), .pin(pin_b));

  // Function select and direction for the two pins.
  wire agw_func_e func24 = agw_func_e'(pin24_config_r[4:`AGW_FUNC_LSB]);
  wire logic alt25 = pin25_config_r[`AGW_BIT_ALT];
  wire logic pin24_drv = func24 == AGW_FUNC_EEPROM_EN
    || (func24 == AGW_FUNC_GPIO && !pin24_config_r[`AGW_BIT_DIR]);
  wire logic pin25_drv = alt25 || !pin25_config_r[`AGW_BIT_DIR];
  wire logic pin24_val = (func24 == AGW_FUNC_EEPROM_EN) ? eeprom_enable_in : gpio_out_r[0];
  wire logic pin25_val = alt25 ? gate_a20_in : gpio_out_r[1];
  assign gpio_pin_oe_out = {pin25_drv, pin24_drv};
  assign gpio_pin_out = {pin25_val ^ pin25_config_r[`AGW_BIT_POL],
    pin24_val ^ pin24_config_r[`AGW_BIT_POL]};

  // Combined interrupt from the enabled, conditioned pins.
  wire logic combined = (pin24_config_r[`AGW_BIT_INTEN] && pin_a.cond_level)
    || (pin25_config_r[`AGW_BIT_INTEN] && pin_b.cond_level);
  assign combined_irq_one_out = irq_route(combined_irq_one_r, combined);
  assign combined_irq_two_out = irq_route(combined_irq_two_r, combined);

  // Either-edge interrupt input 3 pulses on any change of the first pin.
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
      cond_prev_r <= 2'h0;
    else
      cond_prev_r <= {pin_b.cond_level, pin_a.cond_level};
  end
  assign edge_irq3_out = func24 == AGW_FUNC_EDGE_IRQ3
    && (pin_a.cond_level != cond_prev_r[0]);

  // Decoder and strobe enables are gated by the activate bit.
  assign general_address_decoder_en_out = device_active_in
    && decode_strobe_enable_r[`AGW_BIT_DEC_EN];
  assign general_write_strobe_en_out = device_active_in
    && decode_strobe_enable_r[`AGW_BIT_STROBE_EN];

  // Unit tick: one pulse per second, or per minute when minutes are chosen.
  wire logic sec_tick = sec_cnt_r == SECOND_CYCLES - 1;
  wire logic unit_sec = decode_strobe_enable_r[`AGW_BIT_UNIT_SEC];
  wire logic unit_tick = sec_tick
    && (unit_sec || min_cnt_r == 6'(`AGW_SECONDS_PER_MINUTE - 1));
  wire logic wd_off = watchdog_timeout_value_r == 8'h00;
  // Rewriting the value restarts the count, so a new timeout never inherits
  // time already spent under the old one.
  wire logic wd_restart = wr_wdv || watchdog_clear_in;

  // Second divider; it only runs while the watchdog is counting.
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in || wd_state_r != AGW_WD_COUNT || wd_restart || sec_tick)
      sec_cnt_r <= 32'h0;
    else
      sec_cnt_r <= sec_cnt_r + 32'h1;
  end

  // Seconds within the current minute.
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in || wd_state_r != AGW_WD_COUNT || wd_restart || unit_tick)
      min_cnt_r <= 6'h00;
    else if (sec_tick)
      min_cnt_r <= min_cnt_r + 6'h01;
  end

  // Elapsed units, compared against the programmed timeout value.
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in || wd_state_r != AGW_WD_COUNT || wd_restart)
      unit_cnt_r <= 8'h00;
    else if (unit_tick)
      unit_cnt_r <= unit_cnt_r + 8'h01;
  end

  // Expiry falls on the tick that completes the last unit; a restart in the
  // same cycle wins, because software has just serviced the timer.
  wire logic wd_expire = wd_state_r == AGW_WD_COUNT && !wd_restart && unit_tick
    && unit_cnt_r + 8'h01 == watchdog_timeout_value_r;

  // Watchdog state machine; expiry holds until the count is restarted.
  always_comb
  begin
    wd_state_nxt = wd_state_r;
    case (wd_state_r)
      AGW_WD_IDLE:
        if (!wd_off)
          wd_state_nxt = AGW_WD_COUNT;
      AGW_WD_COUNT:
        if (wd_off)
          wd_state_nxt = AGW_WD_IDLE;
        else if (wd_expire)
          wd_state_nxt = AGW_WD_EXPIRED;
      AGW_WD_EXPIRED:
        if (wd_restart)
          wd_state_nxt = AGW_WD_IDLE;
      default:
        wd_state_nxt = AGW_WD_IDLE;
    endcase
  end

  // State register for the watchdog.
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
      wd_state_r <= AGW_WD_IDLE;
    else
      wd_state_r <= wd_state_nxt;
  end

  // Status bit sets on expiry; a clear in the same cycle wins, since it blocks the expiry.
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
      wd_status_r <= 1'b0;
    else if (wd_expire)
      wd_status_r <= 1'b1;
    else if (watchdog_clear_in)
      wd_status_r <= 1'b0;
  end
  assign watchdog_status_out = wd_status_r;

  // Sticky events: bit 0 combined interrupt, bit 1 watchdog expiry.
  wire logic [1:0] event_set = {wd_expire, combined};
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
      event_status_r <= 2'h0;
    else
      event_status_r <= event_set
        | (event_status_r & ~(wr_stat ? reg_wdata_in[1:0] : 2'h0));
  end
  assign irq_out = |(event_status_r & event_mask_r);

  // Read mux; unmapped and reserved indices read zero.
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in || !reg_rd_in)
      rdata_r <= 8'h00;
    else
      case (reg_addr_in)
        `AGW_PIN24_CONFIG_ADDR: rdata_r <= pin24_config_r;
        `AGW_PIN25_CONFIG_ADDR: rdata_r <= pin25_config_r;
        `AGW_COMBINED_IRQ_TWO_ADDR: rdata_r <= combined_irq_two_r;
        `AGW_COMBINED_IRQ_ONE_ADDR: rdata_r <= combined_irq_one_r;
        `AGW_DECODE_STROBE_ENABLE_ADDR: rdata_r <= decode_strobe_enable_r;
        `AGW_WATCHDOG_TIMEOUT_VALUE_ADDR: rdata_r <= watchdog_timeout_value_r;
        `AGW_EVENT_STATUS_ADDR: rdata_r <= {6'h00, event_status_r};
        `AGW_EVENT_MASK_ADDR: rdata_r <= {6'h00, event_mask_r};
        default: rdata_r <= 8'h00;
      endcase
  end
  assign reg_rdata_out = rdata_r;
endmodule

// ---- verif/agw_aux_io_sva.sv ----
// Port-level checker for the auxiliary I/O slice.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ns
module agw_aux_io_sva
#(
  parameter int unsigned SECOND_CYCLES = 4
)
(
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_rd_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic device_active_in,
  input wire logic watchdog_clear_in,
  input wire logic [15:0] combined_irq_one_out,
  input wire logic [15:0] combined_irq_two_out,
  input wire logic general_address_decoder_en_out,
  input wire logic general_write_strobe_en_out,
  input wire logic watchdog_status_out
);
  // All checks share the core clock and are muted during reset.
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (reset_in);

  a_rdata_idle_zero: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
    else $error("read data not zero outside read slot");
  a_rsvd_read_zero: assert property (reg_rd_in && reg_addr_in == 8'hee |=> reg_rdata_out == 8'h00)
    else $error("reserved index read not zero");
  a_decoder_gated: assert property (!device_active_in |-> !general_address_decoder_en_out)
    else $error("decoder enabled while inactive");
  a_strobe_gated: assert property (!device_active_in |-> !general_write_strobe_en_out)
    else $error("write strobe enabled while inactive");
  a_irq_one_map: assert property ($onehot0(combined_irq_one_out) && combined_irq_one_out[0] == 1'b0
    && combined_irq_one_out[2] == 1'b0) else $error("bad first irq routing");
  a_irq_two_map: assert property ($onehot0(combined_irq_two_out) && combined_irq_two_out[0] == 1'b0
    && combined_irq_two_out[2] == 1'b0) else $error("bad second irq routing");
  a_status_after_reset: assert property ($past(reset_in) |-> !watchdog_status_out)
    else $error("watchdog status set after reset");
  a_status_sticky: assert property (watchdog_status_out && !watchdog_clear_in && !reg_wr_in
    |=> watchdog_status_out) else $error("watchdog status dropped by itself");
endmodule

bind agw_aux_io agw_aux_io_sva #(.SECOND_CYCLES(SECOND_CYCLES)) agw_aux_io_sva_inst (
  .core_clk_in, .reset_in, .reg_addr_in, .reg_rd_in, .reg_wr_in, .reg_rdata_out,
  .device_active_in, .watchdog_clear_in, .combined_irq_one_out, .combined_irq_two_out,
  .general_address_decoder_en_out, .general_write_strobe_en_out, .watchdog_status_out);

// ---- verif/agw_pin_dev.sv ----
// External devices on the two general purpose pins.
// Assumes a pull-up on each pin when nobody drives it.
`timescale 1ns/1ns
module agw_pin_dev
(
  input wire logic [1:0] drv_val_in,
  input wire logic [1:0] drv_en_in,
  input wire logic [1:0] dut_val_in,
  input wire logic [1:0] dut_oe_in,
  output logic [1:0] pin_out
);
  // The block wins while it drives; an undriven pin floats up to one.
  always_comb
  begin
    for (int i = 0; i < 2; i++)
      pin_out[i] = dut_oe_in[i] ? dut_val_in[i] : (drv_en_in[i] ? drv_val_in[i] : 1'b1);
  end
endmodule

// ---- verif/agw_tb.sv ----
// Self-checking bench for the auxiliary I/O slice.
// Assumes a short watchdog second so expiry fits in a brief run.
`timescale 1ns/1ns
`include "agw_map.svh"
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wd = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic act = 1'b1;
  logic a20 = 1'b1;
  logic eep = 1'b1;
  logic wclr = 1'b0;
  logic [1:0] xv = 2'b00;
  logic [1:0] xe = 2'b11;
  logic [7:0] rdata;
  logic [1:0] pin, pout, poe;
  logic e3, den, sen, ws, irq;
  logic [15:0] ci1, ci2;
  int err_count = 0;
  int num_checks = 0;
  logic [7:0] ra [7] = '{8'hec, 8'hed, 8'hee, 8'hef, 8'hf0, 8'hf1, 8'hf2};
  logic [7:0] rv [7] = '{8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] rm [7] = '{8'h1f, 8'h0f, 8'h00, 8'hf8, 8'hf8, 8'h83, 8'hff};

  agw_aux_io #(.SECOND_CYCLES(4)) agw_aux_io_inst (
    .core_clk_in(clk), .reset_in(rst), .reg_addr_in(addr), .reg_wdata_in(wd),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .device_active_in(act),
    .gate_a20_in(a20), .eeprom_enable_in(eep), .watchdog_clear_in(wclr),
    .gpio_pin_in(pin), .gpio_pin_out(pout), .gpio_pin_oe_out(poe), .edge_irq3_out(e3),
    .combined_irq_one_out(ci1), .combined_irq_two_out(ci2),
    .general_address_decoder_en_out(den), .general_write_strobe_en_out(sen),
    .watchdog_status_out(ws), .irq_out(irq));
  agw_pin_dev agw_pin_dev_inst (.drv_val_in(xv), .drv_en_in(xe), .dut_val_in(pout),
    .dut_oe_in(poe), .pin_out(pin));

  // Free-running 20 MHz clock.
  initial
  begin
    forever #25 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Bus cycles end just past the edge so the write is already visible.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic t_regs;
    for (int i = 0; i < 7; i++)
      rd_chk(ra[i], rv[i]);
    for (int i = 0; i < 7; i++)
    begin
      wr_reg(ra[i], 8'hff);
      rd_chk(ra[i], rm[i]);
      wr_reg(ra[i], rv[i]);
    end
    rd_chk(8'h10, 8'h00);
  endtask

  task automatic t_irq_map;
    wr_reg(8'hec, 8'h07);
    for (int v = 0; v < 16; v++)
    begin
      wr_reg(8'hf0, 8'(v << 4));
      wr_reg(8'hef, 8'(v << 4));
      chk(ci1, (v == 0 || v == 2) ? 16'h0000 : 16'h0001 << v);
      chk(ci2, (v == 0 || v == 2) ? 16'h0000 : 16'h0001 << v);
    end
    wr_reg(8'hef, 8'h00);
    wr_reg(8'hec, 8'h01);
    chk(ci1, 16'h0000);
  endtask

  task automatic t_dec;
    for (int v = 0; v < 4; v++)
    begin
      wr_reg(8'hf1, 8'(v));
      chk({den, sen}, {v[0], v[1]});
    end
    @(posedge clk) act <= 1'b0;
    cyc(1);
    chk({den, sen}, 2'b00);
    @(posedge clk) act <= 1'b1;
  endtask

  task automatic t_edge(input logic [7:0] cfg, input int e);
    int n = 0;
    wr_reg(8'hec, cfg);
    @(posedge clk) xv[0] <= ~xv[0];
    repeat (8)
    begin
      @(posedge clk);
      #1;
      n += int'(e3 === 1'b1);
    end
    chk(16'(n), 16'(e));
  endtask

  task automatic t_pins;
    wr_reg(8'hf8, 8'h02);
    wr_reg(8'hed, 8'h00);
    chk({poe[1], pout[1]}, 2'b11);
    wr_reg(8'hed, 8'h02);
    chk({poe[1], pout[1]}, 2'b10);
    wr_reg(8'hed, 8'h01);
    chk(poe[1], 1'b0);
    wr_reg(8'hed, 8'h09);
    @(posedge clk) a20 <= 1'b0;
    cyc(1);
    chk({poe[1], pout[1]}, 2'b10);
    wr_reg(8'hec, 8'h09);
    chk({poe[0], pout[0]}, 2'b11);
    wr_reg(8'hec, 8'h19);
    chk(poe[0], 1'b0);
    wr_reg(8'hed, 8'h01);
    t_edge(8'h11, 1);
    t_edge(8'h01, 0);
  endtask

  task automatic t_comb;
    @(posedge clk) xv <= 2'b00;
    wr_reg(8'hec, 8'h05);
    wr_reg(8'hf0, 8'h30);
    wr_reg(8'hf9, 8'h01);
    wr_reg(8'hf8, 8'h03);
    @(posedge clk) xv[0] <= 1'b1;
    cyc(6);
    chk(irq, 1'b1);
    wr_reg(8'hf9, 8'h00);
    chk(irq, 1'b0);
    wr_reg(8'hf9, 8'h01);
    @(posedge clk) xv[0] <= 1'b0;
    cyc(6);
    wr_reg(8'hf8, 8'h01);
    chk(irq, 1'b0);
    wr_reg(8'hec, 8'h07);
    cyc(6);
    chk(irq, 1'b1);
    wr_reg(8'hec, 8'h01);
    wr_reg(8'hf8, 8'h01);
    @(posedge clk) xv[0] <= 1'b1;
    cyc(6);
    chk(irq, 1'b0);
    @(posedge clk) xv[0] <= 1'b0;
    wr_reg(8'hec, 8'h05);
    wr_reg(8'hf0, 8'h38);
    cyc(30);
    wr_reg(8'hf8, 8'h01);
    @(posedge clk) xv[0] <= 1'b1;
    cyc(4);
    @(posedge clk) xv[0] <= 1'b0;
    cyc(30);
    chk(irq, 1'b0);
    @(posedge clk) xv[0] <= 1'b1;
    cyc(30);
    chk(irq, 1'b1);
    wr_reg(8'hf9, 8'h02);
  endtask

  task automatic t_wd;
    wr_reg(8'hf1, 8'h80);
    wr_reg(8'hf2, 8'h03);
    cyc(8);
    chk(ws, 1'b0);
    cyc(10);
    chk({ws, irq}, 2'b11);
    wr_reg(8'hf2, 8'h00);
    @(posedge clk) wclr <= 1'b1;
    @(posedge clk) wclr <= 1'b0;
    cyc(100);
    chk(ws, 1'b0);
    wr_reg(8'hf1, 8'h00);
    wr_reg(8'hf2, 8'h01);
    cyc(200);
    chk(ws, 1'b0);
    cyc(60);
    chk(ws, 1'b1);
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Main sequence after a 16-cycle reset.
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_irq_map();
    t_dec();
    t_pins();
    t_comb();
    t_wd();
    finish_test();
  end

  // Watchdog cuts a hang well past the expected run length.
  initial
  begin
    #1000000;
    err_count++;
    finish_test();
  end
endmodule
